// ==== src/ppd_pkg.sv ====
/*
  ppd_pkg: shared constants and carrier types for the per-phase pedestrian,
  delay, conflict and yellow-omit option block.
  assumes an eight-phase, dual-ring sequencer drives per-phase state inputs.
*/
package ppd_pkg;
  localparam int unsigned NPH          = 8;
  localparam int unsigned PW           = 3;   // phase index width
  localparam int unsigned TW           = 8;   // seconds field width
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned SEC_CYC      = CLK_HZ;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_WDSEL     = 8'h04;
  localparam logic [7:0] OFS_CONFL     = 8'h08;
  localparam logic [7:0] OFS_YSUP      = 8'h0C;
  localparam logic [7:0] OFS_PEDTGT    = 8'h10;
  localparam logic [7:0] OFS_DLYLO     = 8'h14;
  localparam logic [7:0] OFS_DLYHI     = 8'h18;
  localparam logic [7:0] OFS_STAT      = 8'h1C;
  localparam logic [7:0] OFS_DIAG      = 8'h20;
  localparam logic [7:0] OFS_DWELL     = 8'h24;

  // control register fields, reset value and delay status codes
  localparam int unsigned CTRL_YSA     = 0;
  localparam int unsigned CTRL_HCW     = 1;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam logic [1:0]  DLY_NONE     = 2'h0;
  localparam logic [1:0]  DLY_WALK     = 2'h1;   // delayed walk pending
  localparam logic [1:0]  DLY_GREEN    = 2'h2;   // leading walk, green held

  typedef struct packed {
    logic       active;     // phase being served
    logic       enter;      // one-cycle pulse: service begins
    logic       ped_call;   // pending pedestrian call
    logic       walk_end;   // one-cycle pulse: walk timer done
    logic       yellow;     // timing yellow clearance
    logic       ovl_first;  // phase is first of a pedestrian overlap
  } ppd_phase_t;

  typedef struct packed {
    logic [TW-1:0] split;
    logic [TW-1:0] walk;
    logic [TW-1:0] pclr;
    logic [TW-1:0] ycl;
  } ppd_time_t;

  function automatic logic [PW-1:0] ppd_idx(input logic [3:0] num);
    ppd_idx = PW'(num - 4'h1);
  endfunction
endpackage

// ==== src/ppd_options.sv ====
/*
  ppd_options: per-phase option logic (delay of walk or green, conflict
  barriers, yellow omit, pedestrian output steering and overlap).
  assumes phase state inputs are synchronous to clock_i from the sequencer.
*/
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module ppd_options
  import ppd_pkg::*;
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // sequencer state
  input  wire ppd_phase_t [NPH-1:0] phase_i,
  input  wire ppd_time_t  [NPH-1:0] times_i,
  input  wire logic              preempt_i,
  input  wire logic              manual_adv_i,
  input  wire logic [NPH-1:0]    start_req_i,
  input  wire logic [NPH-1:0]    ring2_i,
  input  wire logic [NPH-1:0]    ovl_green_i,
  input  wire logic [NPH-1:0]    ovl_red_i,
  // indications
  output logic      [NPH-1:0]    green_en_o,
  output logic      [NPH-1:0]    walk_o,
  output logic      [NPH-1:0]    pclr_o,
  output logic      [NPH-1:0]    yellow_o,
  output logic      [NPH-1:0]    start_ok_o,
  output logic      [NPH-1:0]    ovl_walk_o,
  output logic      [NPH-1:0]    ovl_pclr_o
);
  logic [31:0]         ctrl_reg;
  logic [NPH-1:0]      wdsel_reg;
  logic [NPH-1:0]      dwell_reg;
  logic [NPH*4-1:0]    confl_reg;
  logic [NPH*4-1:0]    ysup_reg;
  logic [NPH*4-1:0]    pedtgt_reg;
  logic [NPH*TW-1:0]   dly_reg;
  logic [1:0]          dstat_reg [NPH];
  logic [31:0]         dcnt_reg  [NPH];
  logic [NPH-1:0]      walk_int_reg;
  logic [NPH-1:0]      hold_reg;
  logic [NPH-1:0]      diag_reg;
  logic [NPH-1:0]      cmat     [NPH];
  logic [NPH-1:0]      walk_src, yel_next, start_next;
  logic [NPH-1:0]      walk_next, pclr_next;
  logic                wr_en;
  logic [31:0]         rd_next;
  logic                err_next;

  function automatic logic [3:0] nib(input logic [NPH*4-1:0] v, input int unsigned i);
    nib = v[i*4 +: 4];
  endfunction

  assign wr_en = psel_i && penable_i && pwrite_i && ce_i;

  // registers written by software; zero-wait slave
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_reg   <= RST_ZERO;
      wdsel_reg  <= '0;
      dwell_reg  <= '0;
      confl_reg  <= '0;
      ysup_reg   <= '0;
      pedtgt_reg <= '0;
      dly_reg    <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr_i)
        OFS_CTRL:   ctrl_reg   <= pwdata_i & 32'h0000_0003;
        OFS_WDSEL:  wdsel_reg  <= pwdata_i[NPH-1:0];
        OFS_DWELL:  dwell_reg  <= pwdata_i[NPH-1:0];
        OFS_CONFL:  confl_reg  <= pwdata_i;
        OFS_YSUP:   ysup_reg   <= pwdata_i;
        OFS_PEDTGT: pedtgt_reg <= pwdata_i;
        OFS_DLYLO:  dly_reg[31:0]  <= pwdata_i;
        OFS_DLYHI:  dly_reg[63:32] <= pwdata_i;
        default:    ;
      endcase
    end
  end

  always_comb
  begin
    rd_next  = '0;
    err_next = 1'b0;
    unique case (paddr_i)
      OFS_CTRL:   rd_next = ctrl_reg;
      OFS_WDSEL:  rd_next = {24'h00_0000, wdsel_reg};
      OFS_DWELL:  rd_next = {24'h00_0000, dwell_reg};
      OFS_CONFL:  rd_next = confl_reg;
      OFS_YSUP:   rd_next = ysup_reg;
      OFS_PEDTGT: rd_next = pedtgt_reg;
      OFS_DLYLO:  rd_next = dly_reg[31:0];
      OFS_DLYHI:  rd_next = dly_reg[63:32];
      OFS_STAT:
        for (int i = 0; i < NPH; i++)
          rd_next[i*2 +: 2] = dstat_reg[i];
      OFS_DIAG:   rd_next = {24'h00_0000, diag_reg};
      default:    err_next = 1'b1;
    endcase
  end

  // read data and ready registered in setup so the access edge closes it
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pready_o  <= psel_i && !penable_i;
      prdata_o  <= (psel_i && !penable_i) ? rd_next : '0;
      pslverr_o <= psel_i && !penable_i && err_next;
    end
  end

  // one-sided entries made mutual
  always_comb
  begin
    for (int i = 0; i < NPH; i++)
      cmat[i] = '0;
    for (int i = 0; i < NPH; i++)
      if (nib(confl_reg, i) != 4'h0 && nib(confl_reg, i) <= 4'(NPH))
      begin
        cmat[i][ppd_idx(nib(confl_reg, i))] = 1'b1;
        cmat[ppd_idx(nib(confl_reg, i))][i] = 1'b1;
      end
  end

  // start permission: a conflicting ring 2 phase yields at a shared start
  always_comb
  begin
    for (int i = 0; i < NPH; i++)
    begin
      start_next[i] = start_req_i[i];
      for (int j = 0; j < NPH; j++)
        if (cmat[i][j] && phase_i[j].active)
          start_next[i] = 1'b0;
        else if (cmat[i][j] && start_req_i[j] && ring2_i[i] && !ring2_i[j])
          start_next[i] = 1'b0;
    end
  end

  // delay engine, one per phase; time held in seconds, counted in cycles
  for (genvar g = 0; g < NPH; g++)
  begin : g_dly
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        dstat_reg[g] <= DLY_NONE;
        dcnt_reg[g]  <= '0;
      end
      else if (ce_i)
      begin
        if (phase_i[g].enter && phase_i[g].ped_call && !phase_i[g].active
            && !preempt_i && !manual_adv_i && dly_reg[g*TW +: TW] != '0)
        begin
          dstat_reg[g] <= wdsel_reg[g] ? DLY_WALK : DLY_GREEN;
          dcnt_reg[g]  <= 32'(dly_reg[g*TW +: TW]) * 32'(SEC_CYC) - 32'h0000_0001;
        end
        else if (dstat_reg[g] != DLY_NONE)
        begin
          if (preempt_i || manual_adv_i || !phase_i[g].active && !phase_i[g].enter)
            dstat_reg[g] <= DLY_NONE;
          else if (dcnt_reg[g] == '0)
            dstat_reg[g] <= DLY_NONE;
          else
            dcnt_reg[g] <= dcnt_reg[g] - 32'h0000_0001;
        end
      end
    end
  end

  // internal walk and overlap hold; the diagnostic is registered with the outputs
  always_comb
  begin
    for (int i = 0; i < NPH; i++)
    begin
      walk_src[i] = phase_i[i].active && phase_i[i].ped_call
                    && dstat_reg[i] != DLY_WALK && !phase_i[i].walk_end;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      walk_int_reg <= '0;
      hold_reg     <= '0;
    end
    else if (ce_i)
      for (int i = 0; i < NPH; i++)
      begin
        walk_int_reg[i] <= walk_src[i];
        if (phase_i[i].ovl_first && phase_i[i].walk_end
            && phase_i[(i+1)%NPH].ped_call)
          hold_reg[i] <= 1'b1;
        else if (phase_i[(i+1)%NPH].enter)
          hold_reg[i] <= 1'b0;
      end
  end

  // steering of ped outputs; overlap second phase ends it with own times
  always_comb
  begin
    walk_next = '0;
    pclr_next = '0;
    for (int i = 0; i < NPH; i++)
    begin
      logic [PW-1:0] t;
      t = (nib(pedtgt_reg, i) != 4'h0) ? ppd_idx(nib(pedtgt_reg, i)) : PW'(i);
      if (walk_int_reg[i] || hold_reg[i])
        walk_next[t] = 1'b1;
      if (phase_i[i].active && phase_i[i].ped_call && !walk_int_reg[i]
          && dstat_reg[i] == DLY_NONE && !phase_i[i].yellow)
        pclr_next[t] = 1'b1;
    end
    walk_next = walk_next & ~pclr_next;
  end

  always_comb
  begin
    for (int i = 0; i < NPH; i++)
    begin
      yel_next[i] = phase_i[i].yellow;
      if (ctrl_reg[CTRL_YSA] && nib(ysup_reg, i) != 4'h0
          && phase_i[ppd_idx(nib(ysup_reg, i))].yellow)
        yel_next[i] = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      green_en_o <= '0;
      walk_o     <= '0;
      pclr_o     <= '0;
      yellow_o   <= '0;
      start_ok_o <= '0;
      ovl_walk_o <= '0;
      ovl_pclr_o <= '0;
      diag_reg   <= '0;
    end
    else if (ce_i)
      for (int i = 0; i < NPH; i++)
      begin
        logic [TW+2:0] need;
        logic          ped_in;
        ped_in = !ctrl_reg[CTRL_HCW] || dwell_reg[i];
        need = (TW+3)'(dly_reg[i*TW +: TW]) + (TW+3)'(times_i[i].ycl);
        if (ped_in)
          need = need + (TW+3)'(times_i[i].walk) + (TW+3)'(times_i[i].pclr);
        diag_reg[i]   <= (TW+3)'(times_i[i].split) < need;
        green_en_o[i] <= phase_i[i].active && dstat_reg[i] != DLY_GREEN;
        walk_o[i]     <= walk_next[i];
        pclr_o[i]     <= pclr_next[i];
        yellow_o[i]   <= yel_next[i];
        start_ok_o[i] <= start_next[i];
        ovl_walk_o[i] <= ovl_green_i[i];
        ovl_pclr_o[i] <= ovl_red_i[i];
      end
  end

  // checks other than the two overlap ones watch phase 1 (index 0) and its partners; the logic is the same for every
  // phase, so one representative keeps the property count small

  a_yel_omit: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && !ctrl_reg[CTRL_YSA] |=> yellow_o[0] == $past(phase_i[0].yellow) || !$past(ce_i))
    else $error("yellow omitted without unit allow");

  a_conf_mutual: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i |=> !(start_ok_o[0] && start_ok_o[4] && $past(cmat[0][4])))
    else $error("conflicting phases both started");

  a_ovl_walk: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i |=> ovl_walk_o == $past(ovl_green_i))
    else $error("overlap walk not from green");

  a_no_dly_preempt: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && preempt_i |=> dstat_reg[0] == DLY_NONE)
    else $error("delay during preemption");

  // overlap clearance follows the overlap's red state
  a_ovl_pclr: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i
    |=> ovl_pclr_o == $past(ovl_red_i))
    else $error("overlap clearance not from red");

  // both in yellow with the unit allow set: own yellow goes dark
  a_yel_blank: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && ctrl_reg[CTRL_YSA] && nib(ysup_reg, 0) != 4'h0 && phase_i[ppd_idx(nib(ysup_reg, 0))].yellow
    |=> !yellow_o[0])
    else $error("own yellow shown while partner clears");

  // ring 2 phase yields to a conflicting ring 1 phase at a shared start
  a_ring2_skip: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && cmat[4][0] && start_req_i[0] && ring2_i[4] && !ring2_i[0]
    |=> !start_ok_o[4])
    else $error("ring 2 conflicting phase not skipped");

  // leading walk: vehicle indication stays red while the delay runs
  a_green_held: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && dstat_reg[0] == DLY_GREEN
    |=> !green_en_o[0])
    else $error("green shown during leading walk");

  // delayed walk: no walk on the own outputs until the delay ends
  a_walk_delay: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && dstat_reg[0] == DLY_WALK && pedtgt_reg == '0 && !hold_reg[0]
    |=> !walk_o[0])
    else $error("walk shown during walk delay");

  // interval advance under manual control never leaves a delay running
  a_no_dly_manual: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && manual_adv_i
    |=> dstat_reg[0] == DLY_NONE)
    else $error("delay during manual advance");

  // a phase entered while already active starts no delay
  a_no_dly_active: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && phase_i[0].enter && phase_i[0].active && dstat_reg[0] == DLY_NONE
    |=> dstat_reg[0] == DLY_NONE)
    else $error("delay started on an active phase");

  // steered walk lands on the target phase's outputs
  a_walk_steer: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ce_i && walk_int_reg[0] && nib(pedtgt_reg, 0) == 4'h2 && !pclr_next[1]
    |=> walk_o[1])
    else $error("walk not steered to target phase");
endmodule
`default_nettype wire

// ==== sim/ppd_seq_model.sv ====
/*
  ppd_seq_model: minimal sequencer model driving per-phase state.
  assumes the bench pulses go_i for one cycle per phase service.
*/
`timescale 1ns/1ps
`default_nettype none
module ppd_seq_model
  import ppd_pkg::*;
(
  // clock and reset
  input  wire logic            clock_i,
  input  wire logic            nrst_i,
  // commands
  input  wire logic            go_i,
  input  wire logic [PW-1:0]   idx_i,
  input  wire logic            ped_i,
  input  wire logic            act_i,
  input  wire logic [NPH-1:0]  yel_i,
  // phase state
  output var ppd_phase_t [NPH-1:0] phase_o
);
  // a phase stays active until another phase is selected
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      phase_o <= '0;
    else
      for (int i = 0; i < NPH; i++)
      begin
        phase_o[i].enter     <= go_i && (idx_i == PW'(i));
        phase_o[i].ped_call  <= ped_i && (idx_i == PW'(i));
        phase_o[i].active    <= (idx_i == PW'(i))
                                && (act_i || phase_o[i].enter || phase_o[i].active);
        phase_o[i].walk_end  <= 1'b0;
        phase_o[i].yellow    <= yel_i[i];
        phase_o[i].ovl_first <= 1'b0;
      end
  end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
  tb_top: self-checking bench for ppd_options with a sequencer model.
  assumes zero-wait apb answers and one-cycle output latency, two for walk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ppd_pkg::*;
  logic                   clock_i = 1'b0;
  logic                   nrst_i  = 1'b0;
  logic                   psel = 1'b0, pen = 1'b0, pw = 1'b0, pre = 1'b0;
  logic                   go = 1'b0, ped = 1'b0, act = 1'b0, look = 1'b0;
  logic [7:0]             pa = 8'h00;
  logic [31:0]            pd = 32'h0000_0000;
  logic [31:0]            prdata;
  logic                   pready, pslverr;
  logic [PW-1:0]          idx = '0;
  logic [NPH-1:0]         ymask = '0, sreq = '0, r2 = '0, og = '0, orr = '0;
  logic [NPH-1:0]         green, walk, pclr, yel, sok, ow, op;
  ppd_phase_t [NPH-1:0]   ph;
  ppd_time_t  [NPH-1:0]   tm = '0;
  logic [32:0]            rq [$];
  logic [10:0]            iq [$];
  int                     failures = 0;
  int                     check_count = 0;
  integer                 seed = 32'h33b9a4c2;
  localparam logic [6:0]  TAB [5] = '{7'h65, 7'h22, 7'h74, 7'h44, 7'h2C};

  always #5 clock_i = ~clock_i;

  ppd_seq_model u_seq (.clock_i(clock_i), .nrst_i(nrst_i), .go_i(go), .idx_i(idx),
    .ped_i(ped), .act_i(act), .yel_i(ymask), .phase_o(ph));
  ppd_options dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .phase_i(ph), .times_i(tm), .preempt_i(pre),
    .manual_adv_i(1'b0), .start_req_i(sreq), .ring2_i(r2), .ovl_green_i(og),
    .ovl_red_i(orr), .green_en_o(green), .walk_o(walk), .pclr_o(pclr), .yellow_o(yel),
    .start_ok_o(sok), .ovl_walk_o(ow), .ovl_pclr_o(op));

  task finish_test();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task cmp_rd(input logic [32:0] e);
    check_count++;
    if ({pslverr, prdata} !== e)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, {pslverr, prdata}, e);
    end
  endtask

  task cmp_ind(input logic [10:0] e);
    logic [7:0] g;
    case (e[10:8])
      3'h0: g = yel;
      3'h1: g = sok;
      3'h2: g = ow;
      3'h3: g = op;
      3'h4: g = walk;
      3'h6: g = pclr;
      default: g = green;
    endcase
    check_count++;
    if (g !== e[7:0])
    begin
      failures++;
      $display("ERROR t=%0t kind=%h got=%h exp=%h", $time, e[10:8], g, e[7:0]);
    end
  endtask

  // results are matched to the oldest note as they appear
  always @(posedge clock_i)
  begin
    if (psel && pen && !pw && pready === 1'b1)
      cmp_rd(rq.pop_front());
    if (look)
      cmp_ind(iq.pop_front());
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen  <= 1'b0;
    pw   <= w;
    pa   <= a;
    pd   <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clock_i);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    rq.push_back({er, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // inputs must have settled for three edges before the look
  task ind(input logic [2:0] k, input logic [7:0] e);
    repeat (3) @(posedge clock_i);
    iq.push_back({k, e});
    look <= 1'b1;
    @(posedge clock_i);
    look <= 1'b0;
    @(posedge clock_i);
  endtask

  task rst();
    nrst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
  endtask

  task svc(input logic p, input logic a);
    idx <= '0;
    ped <= p;
    act <= a;
    go  <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge clock_i);
    failures++;
    finish_test();
  end

  initial
  begin
    logic [6:0]  e;
    logic [31:0] v;
    rst();
    rd(OFS_WDSEL, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000, 1'b1);
    tm <= {NPH{32'h0205_0501}};
    repeat (2) @(posedge clock_i);
    rd(OFS_DIAG, 32'h0000_00FF);
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    rd(OFS_DIAG, 32'h0000_0000);
    apb(1'b1, OFS_DWELL, 32'h0000_0001);
    rd(OFS_DIAG, 32'h0000_0001);
    tm <= {NPH{32'hC805_0501}};
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    rd(OFS_DIAG, 32'h0000_0000);
    ymask <= 8'h21;
    apb(1'b1, OFS_YSUP, 32'h0000_0006);
    ind(3'h0, 8'h21);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    ind(3'h0, 8'h20);
    ymask <= 8'h01;
    ind(3'h0, 8'h01);
    ymask <= 8'h00;
    sreq <= 8'h11;
    r2   <= 8'h10;
    ind(3'h1, 8'h11);
    apb(1'b1, OFS_CONFL, 32'h0000_0005);
    ind(3'h1, 8'h01);
    apb(1'b1, OFS_CONFL, 32'h0001_0000);
    ind(3'h1, 8'h01);
    sreq <= 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      og  <= v[7:0];
      orr <= v[15:8];
      ind(3'h2, v[7:0]);
      ind(3'h3, v[15:8]);
    end
    apb(1'b1, OFS_PEDTGT, 32'h0000_0022);
    svc(1'b1, 1'b0);
    ind(3'h4, 8'h02);
    ind(3'h6, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      e = TAB[k];
      rst();
      apb(1'b1, OFS_DLYLO, 32'h0000_0001);
      apb(1'b1, OFS_WDSEL, {31'h0000_0000, e[6]});
      pre <= e[3];
      svc(e[5], e[4]);
      rd(OFS_STAT, {30'h0000_0000, e[1:0]});
      ind(3'h5, {7'h00, e[2]});
      pre <= 1'b0;
    end
    finish_test();
  end
endmodule
`default_nettype wire
